//--- design/assc_ctrl.sv
// Association status, forced actions, channel scans and link security.
// Assumes host commands arrive as one-cycle strobes and the radio MAC
// reports beacons, energy samples and association outcomes as pulses.
//
// Behaviour
// - Success of start or association reads zero
// - Active scan failures report codes one to six
// - Energy, start and realignment codes seven to ten
// - Association request failures report codes eleven-sixteen
// - Sync loss, disassociation codes; seventeen never
// - Attempt in progress reads all ones
// - Status read-only, follows latest association request
// - Force disassociate drops link, then retries
// - Force poll waits until changes applied
// - Beacon request broadcast on every enabled channel
// - Active dwell is base times two-to-exponent
// - At most five beacon records per scan
// - Record fields in fixed order, security zero
// - Superframe spec bits kept in place
// - Text mode ends fields with carriage return
// - Energy scan reports channel maximum, returns
// - Energy dwell is base times two-to-parameter
// - Encryption switch; packet limit ninety-five bytes
// - Encrypted packets use long source address
// - Plain packets dropped while encryption on
// - Link key write-only, query only acknowledged
// - Ciphertext checksum, sixteen extra vector bytes
// - Every key write acknowledged, invalid ignored
// - Channel mask limited by part variant
`timescale 1ns/10ps
module assc_ctrl
    import assc_pkg::*;
#(
    parameter int unsigned DWELL_CYC = DWELL_BASE_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [7:0] cmd_arg,
    input wire logic [KEY_W-1:0] key_data,
    input wire logic key_has_value,
    input wire logic key_full_width,
    input wire logic text_mode,
    input wire logic is_coordinator,
    input wire logic high_power_part,
    input wire logic [15:0] channel_mask,
    input wire logic command_mode,
    input wire logic changes_applied,
    input wire logic assoc_begin,
    input wire logic assoc_result_valid,
    input wire logic [7:0] assoc_result_code,
    input wire logic sync_lost,
    input wire logic link_lost,
    input wire logic bcn_valid,
    input wire logic [63:0] bcn_addr,
    input wire logic bcn_long,
    input wire logic [15:0] bcn_net,
    input wire logic [15:0] bcn_superframe,
    input wire logic bcn_slot_permit,
    input wire logic [7:0] bcn_rssi,
    input wire logic [23:0] bcn_time,
    input wire logic ed_valid,
    input wire logic [7:0] ed_level,
    input wire logic out_ready,
    input wire logic rx_valid,
    input wire logic rx_encrypted,
    input wire logic [6:0] tx_len,
    output logic cmd_ack,
    output logic cmd_error,
    output logic [7:0] association_status,
    output logic drop_assoc,
    output logic assoc_retry,
    output logic poll_req,
    output logic radio_tune,
    output logic [7:0] radio_channel,
    output logic beacon_req,
    output logic energy_measure,
    output logic [15:0] beacon_dst_addr,
    output logic [15:0] beacon_dst_net,
    output logic scan_busy,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic encryption_enable,
    output logic [KEY_W-1:0] link_key,
    output logic tx_src_long,
    output logic tx_len_ok,
    output logic [4:0] tx_iv_bytes,
    output logic crc_over_cipher,
    output logic rx_forward
);
    function automatic logic [4:0] first_chan(input logic [15:0] m,
                                              input logic [4:0] from);
        logic [4:0] r;
        r = NO_CHAN;
        for (int i = 15; i >= 0; i--)
            if (m[i] && (5'(i) >= from))
                r = 5'(i);
        return r;
    endfunction : first_chan

    function automatic logic [7:0] desc_byte(input logic [DESC_W-1:0] d,
                                             input logic [4:0] i);
        logic [DESC_W-1:0] s;
        s = d << {i, 3'b000};
        return s[DESC_W-1 -: 8];
    endfunction : desc_byte

    // Command decode
    wire c_dis = cmd_valid && (cmd_code == CMD_DISASSOC);
    wire c_poll = cmd_valid && (cmd_code == CMD_POLL);
    wire c_as = cmd_valid && (cmd_code == CMD_ASCAN);
    wire c_es = cmd_valid && (cmd_code == CMD_ESCAN);
    wire c_enc = cmd_valid && (cmd_code == CMD_ENC_SET);
    wire c_kw = cmd_valid && (cmd_code == CMD_KEY_WR);
    wire c_kr = cmd_valid && (cmd_code == CMD_KEY_RD);

    assc_scan_t state_reg, state_next;
    wire idle = state_reg == S_IDLE;
    wire exp_ok = cmd_arg <= EXP_MAX;
    wire scan_go = (c_as || c_es) && exp_ok && idle;
    wire enc_ok = cmd_arg <= 8'h01;
    wire key_ok = key_has_value && key_full_width;
    wire dis_ok = c_dis && !is_coordinator;
    wire cmd_bad = ((c_as || c_es) && !scan_go) || (c_enc && !enc_ok) ||
                   (c_dis && is_coordinator);

    // Association status and forced actions
    logic [7:0] status_reg, status_next;
    logic drop_reg, retry_reg, poll_pend_reg, poll_reg;
    logic ack_reg, err_reg;
    wire code_ok = (assoc_result_code <= ST_NOT_ASSOC) &&
                   (assoc_result_code != ST_RESERVED);
    wire poll_fire = poll_pend_reg && changes_applied && !command_mode;

    always_comb
    begin
        status_next = status_reg;
        if (assoc_result_valid && code_ok)
            status_next = assoc_result_code;
        if (sync_lost)
            status_next = ST_SYNC_LOSS;
        if (link_lost || drop_reg)
            status_next = ST_NOT_ASSOC;
        // A fresh attempt outranks any older outcome
        if (assoc_begin || retry_reg)
            status_next = ST_ATTEMPT;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            status_reg <= ST_RESET;
            drop_reg <= 1'b0;
            retry_reg <= 1'b0;
            poll_pend_reg <= 1'b0;
            poll_reg <= 1'b0;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            drop_reg <= dis_ok;
            retry_reg <= drop_reg;
            // New request wins over the one being served
            poll_pend_reg <= (poll_pend_reg && !poll_fire) || c_poll;
            poll_reg <= poll_fire;
            ack_reg <= cmd_valid && !cmd_bad;
            err_reg <= cmd_bad;
        end
    end

    // Security settings
    logic enc_reg;
    logic [KEY_W-1:0] key_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            enc_reg <= 1'b0;
            key_reg <= '0;
        end
        else
        begin
            if (c_enc && enc_ok)
                enc_reg <= cmd_arg[0];
            // Malformed key writes are acked but leave the key alone
            if (c_kw && key_ok)
                key_reg <= key_data;
        end
    end

    // Scan engine
    logic active_reg, tune_reg, cr_pend_reg, tail_reg;
    logic [2:0] exp_reg, desc_cnt_reg;
    logic [4:0] chan_reg, en_cnt_reg, item_reg, byte_reg;
    logic [7:0] max_reg, out_reg, rchan_reg;
    logic [DESC_W-1:0] desc_mem [0:4];
    logic [7:0] en_mem [0:15];
    logic tmr_done;

    wire [15:0] eff_mask = channel_mask &
                           (high_power_part ? MASK_HP : MASK_STD);
    wire [4:0] nxt_chan = first_chan(eff_mask, chan_reg);
    wire step_found = (state_reg == S_STEP) && (nxt_chan != NO_CHAN);
    wire dwelling = state_reg == S_DWELL;
    wire desc_room = desc_cnt_reg < MAX_DESC;
    wire desc_wr = dwelling && active_reg && bcn_valid && desc_room;
    wire [7:0] chan_code = CHAN_BASE + {3'b000, chan_reg};
    // Short mode shows the 16-bit address in the low bytes
    wire [63:0] addr_shown = bcn_long ? bcn_addr : {48'h0, bcn_addr[15:0]};
    wire [DESC_W-1:0] desc_pack = {addr_shown, bcn_net,
        bcn_long ? MODE_LONG : MODE_SHORT, chan_code,
        24'h000000, bcn_superframe, 7'h00, bcn_slot_permit,
        bcn_rssi, bcn_time};
    wire [7:0] ed_max = (ed_valid && (ed_level > max_reg)) ?
                        ed_level : max_reg;
    wire [4:0] item_cnt = active_reg ? {2'b00, desc_cnt_reg} : en_cnt_reg;
    wire have_item = item_reg < item_cnt;
    wire [7:0] cur_byte = active_reg ?
                          desc_byte(desc_mem[item_reg[2:0]], byte_reg) :
                          en_mem[item_reg[3:0]];
    wire item_last = !active_reg || (byte_reg == DESC_LAST);
    wire fend = !active_reg || assc_field_end(byte_reg);
    wire load = state_reg == S_LOAD;
    wire emit_cr = load && cr_pend_reg;
    wire emit_item = load && !cr_pend_reg && have_item;
    wire emit_tail = load && !cr_pend_reg && !have_item &&
                     text_mode && !tail_reg;
    wire emit_any = emit_cr || emit_item || emit_tail;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE:
                if (scan_go)
                    state_next = S_STEP;
            S_STEP:
                state_next = step_found ? S_DWELL : S_LOAD;
            S_DWELL:
                if (tmr_done)
                    state_next = S_STEP;
            S_LOAD:
                state_next = emit_any ? S_SEND : S_IDLE;
            S_SEND:
                if (out_ready)
                    state_next = S_LOAD;
            default:
                state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= S_IDLE;
            active_reg <= 1'b0;
            exp_reg <= 3'h0;
            chan_reg <= 5'h0;
            desc_cnt_reg <= 3'h0;
            en_cnt_reg <= 5'h0;
            max_reg <= 8'h00;
            tune_reg <= 1'b0;
            rchan_reg <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            tune_reg <= step_found;
            if (scan_go)
            begin
                active_reg <= c_as;
                exp_reg <= cmd_arg[2:0];
                chan_reg <= 5'h0;
                desc_cnt_reg <= 3'h0;
                en_cnt_reg <= 5'h0;
                max_reg <= 8'h00;
            end
            if (step_found)
            begin
                chan_reg <= nxt_chan;
                rchan_reg <= CHAN_BASE + {3'b000, nxt_chan};
            end
            if (desc_wr)
                desc_cnt_reg <= desc_cnt_reg + 3'h1;
            if (dwelling)
                max_reg <= tmr_done ? 8'h00 : ed_max;
            if (dwelling && tmr_done)
            begin
                chan_reg <= chan_reg + 5'h1;
                if (!active_reg)
                    en_cnt_reg <= en_cnt_reg + 5'h1;
            end
        end
    end

    // Result storage holds data only, so it needs no reset
    always_ff @(posedge clk)
    begin
        if (desc_wr)
            desc_mem[desc_cnt_reg] <= desc_pack;
        if (dwelling && tmr_done && !active_reg)
            en_mem[en_cnt_reg[3:0]] <= ed_max;
    end

    // Output formatter: one byte is latched per load, then offered
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            item_reg <= 5'h0;
            byte_reg <= 5'h0;
            cr_pend_reg <= 1'b0;
            tail_reg <= 1'b0;
            out_reg <= 8'h00;
        end
        else if (state_reg == S_STEP && !step_found)
        begin
            item_reg <= 5'h0;
            byte_reg <= 5'h0;
            cr_pend_reg <= 1'b0;
            tail_reg <= 1'b0;
        end
        else if (emit_cr || emit_tail)
        begin
            out_reg <= ASCII_CR;
            cr_pend_reg <= 1'b0;
            tail_reg <= tail_reg || emit_tail;
        end
        else if (emit_item)
        begin
            out_reg <= cur_byte;
            cr_pend_reg <= text_mode && fend;
            item_reg <= item_last ? item_reg + 5'h1 : item_reg;
            byte_reg <= item_last ? 5'h0 : byte_reg + 5'h1;
        end
    end

    assc_dwell_timer #(
        .BASE_CYC(DWELL_CYC)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(step_found),
        .exp_val(exp_reg),
        .done(tmr_done)
    );

    assign cmd_ack = ack_reg;
    assign cmd_error = err_reg;
    assign association_status = status_reg;
    assign drop_assoc = drop_reg;
    assign assoc_retry = retry_reg;
    assign poll_req = poll_reg;
    assign radio_tune = tune_reg;
    assign radio_channel = rchan_reg;
    assign beacon_req = tune_reg && active_reg;
    assign energy_measure = tune_reg && !active_reg;
    assign beacon_dst_addr = BCAST;
    assign beacon_dst_net = BCAST;
    assign scan_busy = !idle;
    assign out_valid = state_reg == S_SEND;
    assign out_data = out_reg;
    assign encryption_enable = enc_reg;
    // Key goes only to the cipher; no path returns it to the host
    assign link_key = key_reg;
    assign tx_src_long = enc_reg;
    assign tx_len_ok = !enc_reg || (tx_len <= MAX_PKT);
    assign tx_iv_bytes = enc_reg ? IV_BYTES : 5'h0;
    assign crc_over_cipher = enc_reg;
    assign rx_forward = rx_valid && (!enc_reg || rx_encrypted);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_begin_marks_busy: assert property (assoc_begin |=>
        association_status == ST_ATTEMPT) else $error("no busy code");
    chk_never_reserved: assert property (
        association_status != ST_RESERVED) else $error("reserved code");
    chk_result_latched: assert property (assoc_result_valid && code_ok &&
        !assoc_begin && !retry_reg && !drop_reg && !sync_lost && !link_lost
        |=> association_status == $past(assoc_result_code))
        else $error("outcome lost");
    chk_drop_then_retry: assert property (dis_ok |=> drop_assoc &&
        !assoc_retry ##1 assoc_retry ##1 association_status == ST_ATTEMPT)
        else $error("bad disassociate");
    chk_poll_deferred: assert property (poll_req |->
        $past(changes_applied && !command_mode)) else $error("early poll");
    chk_plain_dropped: assert property (encryption_enable && rx_valid &&
        !rx_encrypted |-> !rx_forward) else $error("plain rx passed");
    chk_encrypted_tx: assert property (encryption_enable |->
        tx_iv_bytes == IV_BYTES && tx_src_long && crc_over_cipher &&
        (tx_len <= MAX_PKT || !tx_len_ok)) else $error("tx rules");
    chk_desc_limit: assert property (desc_cnt_reg <= 3'h5)
        else $error("too many records");
    chk_key_acked: assert property (c_kw || c_kr |=> cmd_ack)
        else $error("key not acked");
    chk_tune_masked: assert property (radio_tune |->
        eff_mask[4'(radio_channel - CHAN_BASE)]) else $error("bad chan");

    cov_active_found: cover property (desc_wr ##[1:1000] out_valid);
    cov_energy_scan: cover property (energy_measure ##[1:1000] out_valid);
    cov_poll_sent: cover property (c_poll ##[1:20] poll_req);
    cov_key_write: cover property (c_kw && key_ok);
endmodule : assc_ctrl

//--- design/assc_pkg.sv
// Constants and types for the association, scan and security controller.
// Assumes a 200 MHz clock; the radio MAC and cipher engine are outside.
package assc_pkg;
    // Association status codes
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_AS_TIMEOUT = 8'h01;
    localparam logic [7:0] ST_AS_NO_NET = 8'h02;
    localparam logic [7:0] ST_AS_NO_JOIN = 8'h03;
    localparam logic [7:0] ST_AS_BEACON = 8'h04;
    localparam logic [7:0] ST_AS_NET_NUM = 8'h05;
    localparam logic [7:0] ST_AS_CHAN = 8'h06;
    localparam logic [7:0] ST_ED_TIMEOUT = 8'h07;
    localparam logic [7:0] ST_START_FAIL = 8'h08;
    localparam logic [7:0] ST_START_PARAM = 8'h09;
    localparam logic [7:0] ST_REALIGN = 8'h0A;
    localparam logic [7:0] ST_REQ_NOT_SENT = 8'h0B;
    localparam logic [7:0] ST_REQ_TIMEOUT = 8'h0C;
    localparam logic [7:0] ST_REQ_PARAM = 8'h0D;
    localparam logic [7:0] ST_REQ_CCA = 8'h0E;
    localparam logic [7:0] ST_REQ_NO_ACK = 8'h0F;
    localparam logic [7:0] ST_REQ_NO_REPLY = 8'h10;
    localparam logic [7:0] ST_RESERVED = 8'h11;
    localparam logic [7:0] ST_SYNC_LOSS = 8'h12;
    localparam logic [7:0] ST_NOT_ASSOC = 8'h13;
    localparam logic [7:0] ST_ATTEMPT = 8'hFF;
    localparam logic [7:0] ST_RESET = ST_NOT_ASSOC;

    // Host command codes
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_DISASSOC = 3'h1;
    localparam logic [2:0] CMD_POLL = 3'h2;
    localparam logic [2:0] CMD_ASCAN = 3'h3;
    localparam logic [2:0] CMD_ESCAN = 3'h4;
    localparam logic [2:0] CMD_ENC_SET = 3'h5;
    localparam logic [2:0] CMD_KEY_WR = 3'h6;
    localparam logic [2:0] CMD_KEY_RD = 3'h7;

    // Scan and output formatting
    localparam logic [15:0] BCAST = 16'hFFFF;
    localparam logic [15:0] MASK_STD = 16'hFFFF;
    localparam logic [15:0] MASK_HP = 16'h1FFE;
    localparam logic [7:0] CHAN_BASE = 8'h0B;
    localparam logic [7:0] EXP_MAX = 8'h06;
    localparam logic [7:0] ASCII_CR = 8'h0D;
    localparam logic [7:0] MODE_SHORT = 8'h02;
    localparam logic [7:0] MODE_LONG = 8'h03;
    localparam logic [2:0] MAX_DESC = 3'h5;
    localparam logic [4:0] DESC_LAST = 5'h15;
    localparam logic [4:0] NO_CHAN = 5'h10;
    localparam int DESC_W = 176;

    // Security
    localparam logic [6:0] MAX_PKT = 7'h5F;
    localparam logic [4:0] IV_BYTES = 5'h10;
    localparam int KEY_W = 128;

    // Dwell base time per channel
    localparam real DWELL_BASE_MS = 15.36;
    localparam real CLK_MHZ = 200.0;
    localparam int unsigned DWELL_BASE_CYC =
        int'(DWELL_BASE_MS * 1000.0 * CLK_MHZ);

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_STEP = 3'b001,
        S_DWELL = 3'b011,
        S_LOAD = 3'b101,
        S_SEND = 3'b111
    } assc_scan_t;

    // Byte positions that close a field of a network beacon record
    function automatic logic assc_field_end(input logic [4:0] i);
        return (i == 5'h07) || (i == 5'h09) || (i == 5'h0A) ||
               (i == 5'h0B) || (i == 5'h0C) || (i == 5'h0D) ||
               (i == 5'h0E) || (i == 5'h10) || (i == 5'h11) ||
               (i == 5'h12) || (i == DESC_LAST);
    endfunction : assc_field_end
endpackage : assc_pkg

//--- design/assc_dwell_timer.sv
// Per-channel dwell timer: 2^exp repeats of a base period.
// Assumes start is a one-cycle pulse and exp is already range checked.
`timescale 1ns/10ps
module assc_dwell_timer
    import assc_pkg::*;
#(
    parameter int unsigned BASE_CYC = DWELL_BASE_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [2:0] exp_val,
    output logic done
);
    logic run_reg;
    logic [31:0] cnt_reg;
    logic [6:0] rep_reg;
    logic done_reg;
    wire base_end = cnt_reg == 32'(BASE_CYC - 1);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            run_reg <= 1'b0;
            cnt_reg <= 32'h0;
            rep_reg <= 7'h0;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= run_reg && base_end && (rep_reg == 7'h0);
            if (start)
            begin
                run_reg <= 1'b1;
                cnt_reg <= 32'h0;
                rep_reg <= 7'((8'h01 << exp_val) - 8'h01);
            end
            else if (run_reg)
            begin
                cnt_reg <= base_end ? 32'h0 : cnt_reg + 32'h1;
                if (base_end)
                begin
                    run_reg <= rep_reg != 7'h0;
                    rep_reg <= rep_reg - 7'h1;
                end
            end
        end
    end

    assign done = done_reg;
endmodule : assc_dwell_timer

//--- bench/assc_mac_model.sv
// Radio MAC stand-in: answers scan tuning with beacons or energy samples.
// Assumes tune strobes from the controller and a dwell of eight cycles.
`timescale 1ns/10ps
module assc_mac_model
    import assc_pkg::*;
(
    input wire logic clk,
    input wire logic beacon_req,
    input wire logic energy_measure,
    input wire logic [7:0] radio_channel,
    output logic bcn_valid,
    output logic [63:0] bcn_addr,
    output logic [15:0] bcn_net,
    output logic ed_valid,
    output logic [7:0] ed_level
);
    logic [1:0] ed_sh;
    initial
    begin
        ed_sh = 2'h0;
        bcn_valid = 1'b0;
        ed_valid = 1'b0;
        ed_level = 8'h00;
    end
    // Fields follow the channel so a stale record would show up
    // Top byte set so that short mode must hide it
    assign bcn_addr = {8'hA5, 40'h0, radio_channel, 8'hCD};
    assign bcn_net = {8'h12, radio_channel};
    // Two samples per dwell; the later one is the larger
    always @(negedge clk)
    begin
        ed_sh <= {ed_sh[0], energy_measure};
        bcn_valid <= beacon_req;
        ed_valid <= ed_sh[0] | ed_sh[1];
        ed_level <= ed_sh[0] ? radio_channel + 8'h01 : radio_channel + 8'h05;
    end
endmodule : assc_mac_model

//--- bench/tb_top.sv
// Self-checking bench for the association, scan and security controller.
// Assumes the MAC model above as far side; host strobes change at negedge.
`timescale 1ns/10ps
module tb_top
    import assc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_code = CMD_NOP;
    logic [7:0] cmd_arg = 8'h00;
    logic [127:0] key_data = 128'h0;
    logic key_has_value = 1'b0;
    logic key_full_width = 1'b0;
    logic text_mode = 1'b1;
    logic is_coordinator = 1'b0;
    logic high_power_part = 1'b0;
    logic [15:0] channel_mask = 16'h0000;
    logic command_mode = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [7:0] assoc_result_code = 8'h00;
    logic out_ready = 1'b0;
    logic rx_valid = 1'b0;
    logic rx_encrypted = 1'b0;
    logic [6:0] tx_len = 7'h00;
    logic bcn_long = 1'b0;
    logic bcn_valid, ed_valid, cmd_ack, cmd_error, drop_assoc, assoc_retry;
    logic poll_req, beacon_req, energy_measure, scan_busy, out_valid;
    logic encryption_enable, tx_src_long, tx_len_ok, crc_over_cipher;
    logic rx_forward;
    logic [7:0] ed_level, association_status, radio_channel, out_data;
    logic [63:0] bcn_addr;
    logic [15:0] bcn_net, beacon_dst_addr, beacon_dst_net;
    logic [127:0] link_key;
    logic [4:0] tx_iv_bytes;
    logic [7:0] q[$];
    int fails = 0;
    int checked = 0;
    always #2.5 clk = ~clk;
    assc_mac_model mac (.clk(clk), .beacon_req(beacon_req),
        .energy_measure(energy_measure), .radio_channel(radio_channel),
        .bcn_valid(bcn_valid), .bcn_addr(bcn_addr), .bcn_net(bcn_net),
        .ed_valid(ed_valid), .ed_level(ed_level));
    assc_ctrl #(.DWELL_CYC(8)) dut (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
        .key_data(key_data), .key_has_value(key_has_value),
        .key_full_width(key_full_width), .text_mode(text_mode),
        .is_coordinator(is_coordinator), .high_power_part(high_power_part),
        .channel_mask(channel_mask), .command_mode(command_mode),
        .changes_applied(ev[4]), .assoc_begin(ev[0]),
        .assoc_result_valid(ev[1]), .assoc_result_code(assoc_result_code),
        .sync_lost(ev[2]), .link_lost(ev[3]), .bcn_valid(bcn_valid),
        .bcn_addr(bcn_addr), .bcn_long(bcn_long), .bcn_net(bcn_net),
        .bcn_superframe(16'h8F21), .bcn_slot_permit(1'b1),
        .bcn_rssi(8'h28), .bcn_time(24'h010203), .ed_valid(ed_valid),
        .ed_level(ed_level), .out_ready(out_ready), .rx_valid(rx_valid),
        .rx_encrypted(rx_encrypted), .tx_len(tx_len), .cmd_ack(cmd_ack),
        .cmd_error(cmd_error), .association_status(association_status),
        .drop_assoc(drop_assoc), .assoc_retry(assoc_retry),
        .poll_req(poll_req), .radio_tune(), .radio_channel(radio_channel),
        .beacon_req(beacon_req), .energy_measure(energy_measure),
        .beacon_dst_addr(beacon_dst_addr),
        .beacon_dst_net(beacon_dst_net),
        .scan_busy(scan_busy), .out_valid(out_valid), .out_data(out_data),
        .encryption_enable(encryption_enable), .link_key(link_key),
        .tx_src_long(tx_src_long), .tx_len_ok(tx_len_ok),
        .tx_iv_bytes(tx_iv_bytes), .crc_over_cipher(crc_over_cipher),
        .rx_forward(rx_forward));
    // A byte is taken at the edge on which the handshake completes
    always @(posedge clk)
        if (out_valid === 1'b1 && out_ready === 1'b1)
            q.push_back(out_data);
    // Output side stalls every other cycle
    always @(negedge clk)
        out_ready <= ~out_ready;
    task chk(input logic [175:0] got, input logic [175:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task cmd(input logic [2:0] c, input logic [7:0] a, input logic err);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_arg = a;
        @(negedge clk);
        cmd_valid = 1'b0;
        chk(cmd_ack, !err);
        chk(cmd_error, err);
    endtask : cmd
    task pulse(input int b);
        @(negedge clk);
        ev[b] = 1'b1;
        @(negedge clk);
        ev[b] = 1'b0;
    endtask : pulse
    task scan_end(input int n, input logic [175:0] e);
        logic [175:0] p;
        p = 176'h0;
        for (int i = 0; i < 3000 && scan_busy !== 1'b0; i++)
            @(negedge clk);
        foreach (q[i])
            p = {p[167:0], q[i]};
        chk(q.size(), n);
        chk(p, e);
        q.delete();
    endtask : scan_end
    task print_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #100000;
        fails++;
        print_verdict;
    end
    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        chk(association_status, ST_NOT_ASSOC);
        chk({beacon_dst_addr, beacon_dst_net}, {BCAST, BCAST});
        for (int c = 0; c <= 8'h13; c++)
        begin
            pulse(0);
            chk(association_status, ST_ATTEMPT);
            assoc_result_code = c;
            pulse(1);
            chk(association_status, c == 8'h11 ? ST_ATTEMPT : c);
        end
        pulse(2);
        chk(association_status, ST_SYNC_LOSS);
        cmd(CMD_DISASSOC, 8'h00, 1'b0);
        chk(drop_assoc, 1'b1);
        @(negedge clk);
        chk(assoc_retry, 1'b1);
        chk(association_status, ST_NOT_ASSOC);
        @(negedge clk);
        chk(association_status, ST_ATTEMPT);
        is_coordinator = 1'b1;
        cmd(CMD_DISASSOC, 8'h00, 1'b1);
        chk(drop_assoc, 1'b0);
        pulse(3);
        chk(association_status, ST_NOT_ASSOC);
        command_mode = 1'b1;
        cmd(CMD_POLL, 8'h00, 1'b0);
        pulse(4);
        chk(poll_req, 1'b0);
        command_mode = 1'b0;
        pulse(4);
        chk(poll_req, 1'b1);
        channel_mask = 16'h0005;
        cmd(CMD_ESCAN, 8'h00, 1'b0);
        cmd(CMD_ESCAN, 8'h00, 1'b1);
        scan_end(5, 176'h100D120D0D);
        cmd(CMD_ESCAN, 8'h07, 1'b1);
        text_mode = 1'b0;
        channel_mask = 16'h0002;
        cmd(CMD_ASCAN, 8'h01, 1'b0);
        scan_end(22, 176'h0000000000000CCD120C020C0000008F2101280102_03);
        bcn_long = 1'b1;
        cmd(CMD_ASCAN, 8'h00, 1'b0);
        scan_end(22, 176'hA500000000000CCD120C030C0000008F2101280102_03);
        text_mode = 1'b1;
        high_power_part = 1'b1;
        channel_mask = 16'h0001;
        cmd(CMD_ASCAN, 8'h06, 1'b0);
        scan_end(1, 176'h0D);
        cmd(CMD_ENC_SET, 8'h02, 1'b1);
        cmd(CMD_ENC_SET, 8'h01, 1'b0);
        rx_valid = 1'b1;
        tx_len = 7'h5F;
        #1;
        chk(encryption_enable, 1'b1);
        chk({tx_src_long, tx_len_ok, crc_over_cipher}, 3'h7);
        chk({tx_iv_bytes, rx_forward}, {IV_BYTES, 1'b0});
        @(negedge clk);
        tx_len = 7'h60;
        rx_encrypted = 1'b1;
        #1;
        chk({tx_len_ok, rx_forward}, 2'h1);
        key_data = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
        {key_has_value, key_full_width} = 2'h3;
        cmd(CMD_KEY_WR, 8'h00, 1'b0);
        chk(link_key, key_data);
        key_has_value = 1'b0;
        cmd(CMD_KEY_WR, 8'h00, 1'b0);
        cmd(CMD_KEY_RD, 8'h00, 1'b0);
        chk(link_key, 128'h0123456789ABCDEF0F1E2D3C4B5A6978);
        print_verdict;
    end
endmodule : tb_top
